// *** core/flash_prog_mailbox_status.sv ***
// Flash programming mailbox, status register and flash-done interrupt routing.
// Assumes the flash engine supplies busy and lock levels on core_clk.
//
// Functional notes
// RQ1 - High address byte register, index B4, reset zero
// RQ2 - Data mailbox register, index B5, reset zero
// RQ3 - Status bit 3 shows six-clock mode
// RQ4 - Status bit 2 busy flag, resets zero
// RQ5 - Software waits for busy clear before commanding
// RQ6 - Status bits 7..5 show inverted lock bits
// RQ7 - Status register ignores writes; spare bits undefined
// RQ8 - Done-irq enable reroutes external interrupt one
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_mailbox_status
(
    // Clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                reset_n,
    // Avalon-MM slave
    input  wire logic [flash_mbox_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [flash_mbox_pkg::BUS_W-1:0]    avs_writedata,
    input  wire logic [3:0]                          avs_byteenable,
    output logic [flash_mbox_pkg::BUS_W-1:0]         avs_readdata,
    output logic                                     avs_waitrequest,
    // Flash engine side
    input  wire logic                                flash_busy,
    input  wire logic                                flash_data_load,
    input  wire logic [flash_mbox_pkg::DATA_W-1:0]   flash_data_in,
    output logic [flash_mbox_pkg::DATA_W-1:0]        flash_addr_high,
    output logic [flash_mbox_pkg::DATA_W-1:0]        flash_data_mailbox,
    // Option and lock levels
    input  wire logic                                double_speed,
    input  wire logic                                lock_one_prog,
    input  wire logic                                lock_two_prog,
    input  wire logic                                lock_three_prog,
    // Interrupt routing
    input  wire logic                                flash_done_irq_enable,
    input  wire logic                                ext_irq_one_n,
    output logic                                     int_one_request,
    output logic                                     irq
);
    import flash_mbox_pkg::*;

    // Carrier to the bus front end
    reg_access_if regs ();

    // Status register image, refreshed every cycle
    logic [DATA_W-1:0] flash_status;
    // Busy one cycle ago, for the completion edge
    logic              busy_q;
    // External interrupt one level one cycle ago
    logic              ext_one_q_n;
    // Sticky events and their mask
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  next_irq_status;
    logic [IRQ_W-1:0]  irq_events;
    // Completion of a flash operation
    logic              flash_done;

    // Assemble the status byte; spare bits read zero
    function automatic logic [DATA_W-1:0] status_byte(
        input logic l1, input logic l2, input logic l3,
        input logic dbl, input logic busy);
        logic [DATA_W-1:0] b;
        b = ZERO_BYTE;
        b[BIT_LOCK_ONE]   = !l1;
        b[BIT_LOCK_TWO]   = !l2;
        b[BIT_LOCK_THREE] = !l3;
        b[BIT_DOUBLE]     = dbl;
        b[BIT_BUSY]       = busy;
        return b;
    endfunction

    // Bus front end
    avalon_slave_port u_port (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .regs            (regs)
    );

    // High address byte, software only
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            flash_addr_high <= ADDR_HIGH_RST;  // RQ1
        else if (regs.wr_en && regs.idx == IDX_ADDR_HIGH)
            flash_addr_high <= regs.wdata;     // RQ1
    end

    // Data mailbox; a verify byte from the array beats a software write
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            flash_data_mailbox <= DATA_RST;       // RQ2
        else if (flash_data_load)
            flash_data_mailbox <= flash_data_in;  // RQ2
        else if (regs.wr_en && regs.idx == IDX_DATA)
            flash_data_mailbox <= regs.wdata;     // RQ2
    end

    // Status image; no write path exists, so writes leave it alone
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            flash_status <= ZERO_BYTE;  // RQ4
        else
            flash_status <= status_byte(lock_one_prog, lock_two_prog,
                                        lock_three_prog, double_speed,
                                        flash_busy);  // RQ3 RQ4 RQ6 RQ7
    end

    // Edge history for completion and external interrupt one
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            busy_q      <= 1'b0;
            ext_one_q_n <= 1'b1;
        end
        else
        begin
            busy_q      <= flash_busy;
            ext_one_q_n <= ext_irq_one_n;
        end
    end

    // Completion is the fall of busy
    assign flash_done = busy_q && !flash_busy;

    // Interrupt one request: completion when rerouted, else the pin level
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            int_one_request <= 1'b0;
        else if (flash_done_irq_enable)
            int_one_request <= flash_done;      // RQ8
        else
            int_one_request <= !ext_irq_one_n;  // RQ8
    end

    // Events; the pin edge is dropped while rerouted
    always_comb
    begin
        irq_events = IRQ_RST;
        irq_events[IRQ_DONE]    = flash_done;
        irq_events[IRQ_EXT_ONE] = ext_one_q_n && !ext_irq_one_n
                                  && !flash_done_irq_enable;  // RQ8
    end

    // Write-one-to-clear, but a new event in the same cycle wins
    always_comb
    begin
        next_irq_status = irq_status;
        if (regs.wr_en && regs.idx == IDX_IRQ_STATUS)
            next_irq_status = irq_status & ~regs.wdata[IRQ_W-1:0];
        next_irq_status = next_irq_status | irq_events;
    end

    // Sticky status
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            irq_status <= IRQ_RST;
        else
            irq_status <= next_irq_status;
    end

    // Mask, same layout as status
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            irq_mask <= IRQ_RST;
        else if (regs.wr_en && regs.idx == IDX_IRQ_MASK)
            irq_mask <= regs.wdata[IRQ_W-1:0];
    end

    // Registered level interrupt from the next status value and the mask
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |(next_irq_status & irq_mask);
    end

    // Read mux; unmapped indexes read zero
    always_comb
    begin
        unique case (regs.idx)
            IDX_ADDR_HIGH:  regs.rd_data = flash_addr_high;
            IDX_DATA:       regs.rd_data = flash_data_mailbox;
            IDX_STATUS:     regs.rd_data = flash_status;  // RQ7
            IDX_IRQ_STATUS: regs.rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
            IDX_IRQ_MASK:   regs.rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
            default:        regs.rd_data = ZERO_BYTE;
        endcase
    end

    // Checks

    a_addr_high_write: assert property ( // RQ1
        @(posedge core_clk) disable iff (!reset_n)
        regs.wr_en && regs.idx == IDX_ADDR_HIGH
        |=> flash_addr_high == $past(regs.wdata))
        else $error("address high byte did not take the write");

    a_mailbox_load: assert property ( // RQ2
        @(posedge core_clk) disable iff (!reset_n)
        regs.wr_en && regs.idx == IDX_DATA && !flash_data_load
        |=> flash_data_mailbox == $past(regs.wdata))
        else $error("mailbox did not take the write");

    a_clock_mode_bit: assert property ( // RQ3
        @(posedge core_clk) disable iff (!reset_n)
        $rose(double_speed) |=> flash_status[BIT_DOUBLE] ##1 $stable(flash_status[BIT_DOUBLE])
            or !double_speed)
        else $error("clock mode bit does not follow the option");

    a_busy_follows: assert property ( // RQ4
        @(posedge core_clk) disable iff (!reset_n)
        flash_busy ##1 !flash_busy |=> !flash_status[BIT_BUSY] && $past(flash_status[BIT_BUSY]))
        else $error("busy bit did not clear after completion");

    // Sampled reset keeps the release edge, whose image is still zero, out
    a_lock_inverted: assert property ( // RQ6
        @(posedge core_clk) disable iff (!reset_n)
        reset_n |=> flash_status[BIT_LOCK_ONE:BIT_LOCK_THREE]
                 == ~{$past(lock_one_prog), $past(lock_two_prog), $past(lock_three_prog)})
        else $error("lock bits not inverted");

    a_status_readonly: assert property ( // RQ7
        @(posedge core_clk) disable iff (!reset_n)
        regs.wr_en && regs.idx == IDX_STATUS
        |=> $stable(flash_addr_high) && flash_status[BIT_BUSY] == $past(flash_busy))
        else $error("status write disturbed state");

    a_int_one_route: assert property ( // RQ8
        @(posedge core_clk) disable iff (!reset_n)
        flash_done_irq_enable && !flash_done |=> !int_one_request)
        else $error("pin leaked through while rerouted");

    a_done_sticky: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        flash_done |=> irq_status[IRQ_DONE] ##1 (irq == irq_mask[IRQ_DONE]) or !irq_mask[IRQ_DONE])
        else $error("completion event lost");
endmodule
`default_nettype wire

// *** core/flash_mbox_pkg.sv ***
// Constants for the flash programming mailbox and status block.
// Assumes a 32-bit Avalon-MM slave with word-aligned register indexes.
package flash_mbox_pkg;
    // Bus and register widths
    localparam int DATA_W = 8;
    localparam int BUS_W  = 32;
    localparam int ADDR_W = 10;
    localparam int IDX_W  = 8;
    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_ADDR_HIGH  = 8'hB4;
    localparam logic [IDX_W-1:0] IDX_DATA       = 8'hB5;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 8'hB6;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hC0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 8'hC1;
    // Reset values
    localparam logic [DATA_W-1:0] ADDR_HIGH_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST      = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
    // Status field positions
    localparam int BIT_LOCK_ONE   = 7;
    localparam int BIT_LOCK_TWO   = 6;
    localparam int BIT_LOCK_THREE = 5;
    localparam int BIT_DOUBLE     = 3;
    localparam int BIT_BUSY       = 2;
    // Interrupt status and mask layout
    localparam int IRQ_W        = 2;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_EXT_ONE  = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
endpackage

// *** core/reg_access_if.sv ***
// Register access carrier between the bus port and the register file.
// Assumes one clock domain; strobes are single-cycle.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic [7:0] idx;      // Register index
    logic [7:0] wdata;    // Write byte
    logic       wr_en;    // Write commit pulse
    logic [7:0] rd_data;  // Read byte for current index
    modport bus_side  (output idx, output wdata, output wr_en, input rd_data);
    modport regs_side (input idx, input wdata, input wr_en, output rd_data);
endinterface
`default_nettype wire

// *** core/avalon_slave_port.sv ***
// Avalon-MM slave front end: one wait cycle, then the answer.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module avalon_slave_port
    import flash_mbox_pkg::*;
(
    // Clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                reset_n,
    // Avalon-MM slave
    input  wire logic [flash_mbox_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [flash_mbox_pkg::BUS_W-1:0]    avs_writedata,
    input  wire logic [3:0]                          avs_byteenable,
    output logic [flash_mbox_pkg::BUS_W-1:0]         avs_readdata,
    output logic                                     avs_waitrequest,
    // Register side
    reg_access_if.bus_side                           regs
);
    // Word index; low address bits ignored for aligned words
    assign regs.idx   = avs_address[ADDR_W-1:2];
    assign regs.wdata = avs_writedata[DATA_W-1:0];
    // Write lands only on the edge that ends the wait, low lane only
    assign regs.wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];

    // Wait state: low for exactly one cycle after a request appears
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    // Read data captured during the wait, stable at the answer edge
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= {{(BUS_W-DATA_W){1'b0}}, regs.rd_data};
    end
endmodule
`default_nettype wire

// *** test/flash_prog_mailbox_status_tb_top.sv ***
// Self-checking bench for the flash mailbox, status and interrupt block.
// Assumes the package and design files under core/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_mailbox_status_tb_top;
    import flash_mbox_pkg::*;
    // Bench-driven inputs
    logic                core_clk, reset_n, avs_read, avs_write;
    logic [ADDR_W-1:0]   avs_address;
    logic [BUS_W-1:0]    avs_writedata;
    logic [3:0]          avs_byteenable;
    logic                flash_busy, flash_data_load, double_speed;
    logic                lock_one_prog, lock_two_prog, lock_three_prog;
    logic                flash_done_irq_enable, ext_irq_one_n;
    logic [DATA_W-1:0]   flash_data_in;
    // Design outputs
    logic [BUS_W-1:0]    avs_readdata;
    logic                avs_waitrequest, int_one_request, irq;
    logic [DATA_W-1:0]   flash_addr_high, flash_data_mailbox;
    // Scoreboard
    int                  n_errors, comparisons;

    // Device under test
    flash_prog_mailbox_status uut
    (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flash_busy(flash_busy),
        .flash_data_load(flash_data_load), .flash_data_in(flash_data_in),
        .flash_addr_high(flash_addr_high), .flash_data_mailbox(flash_data_mailbox),
        .double_speed(double_speed), .lock_one_prog(lock_one_prog),
        .lock_two_prog(lock_two_prog), .lock_three_prog(lock_three_prog),
        .flash_done_irq_enable(flash_done_irq_enable), .ext_irq_one_n(ext_irq_one_n),
        .int_one_request(int_one_request), .irq(irq)
    );

    // 10 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Case-equality compare; unknowns never match
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr_n_rd, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_read      <= !wr_n_rd;
        avs_write     <= wr_n_rd;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        // Data is taken at the very edge that ends the access
        q = avs_readdata[7:0];
        // One wait edge, then the answer edge; a hang ends in the watchdog
        chk("wait edges", 32'h0000_0002, n);
        if (!wr_n_rd)
            chk("readdata upper", 32'h0000_0000, {8'h00, avs_readdata[31:8]});
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(what, exp, q);
    endtask

    // Software side: poll the status busy bit until the engine is idle
    task automatic poll_idle();
        logic [7:0] q;
        q = 8'hFF;
        while (q[BIT_BUSY] !== 1'b0)
            bus(1'b0, IDX_STATUS, 8'h00, q);
    endtask

    // Counts high cycles of int_one_request, sampled mid-cycle; returns on a rising edge
    task automatic count(input int k, output int n);
        n = 0;
        repeat (k)
        begin
            @(negedge core_clk);
            n += (int_one_request === 1'b1);
        end
        @(posedge core_clk);
    endtask

    // Read/write registers, byte enable, unmapped space, mid-run reset
    task automatic t_regs();
        wr(IDX_ADDR_HIGH, 8'hA5);
        wr(IDX_DATA, 8'h5A);
        rdchk("addr high", IDX_ADDR_HIGH, 8'hA5);
        rdchk("mailbox", IDX_DATA, 8'h5A);
        chk("addr out", 8'hA5, flash_addr_high);
        avs_byteenable <= 4'h0;
        wr(IDX_ADDR_HIGH, 8'h11);
        avs_byteenable <= 4'h1;
        rdchk("lane off write", IDX_ADDR_HIGH, 8'hA5);
        rdchk("unmapped", 8'h20, 8'h00);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rdchk("addr high reset", IDX_ADDR_HIGH, 8'h00);
        rdchk("mailbox reset", IDX_DATA, 8'h00);
        rdchk("status reset", IDX_STATUS, 8'hE0);
    endtask

    // Flash side loads the mailbox
    task automatic t_load();
        @(posedge core_clk);
        flash_data_in   <= 8'hC3;
        flash_data_load <= 1'b1;
        @(posedge core_clk);
        flash_data_load <= 1'b0;
        rdchk("loaded mailbox", IDX_DATA, 8'hC3);
        chk("mailbox out", 8'hC3, flash_data_mailbox);
    endtask

    // Every lock, speed and busy combination, then an ignored write
    task automatic t_status();
        for (int i = 0; i < 32; i++)
        begin
            @(posedge core_clk);
            {lock_one_prog, lock_two_prog, lock_three_prog, double_speed, flash_busy} <= i[4:0];
            repeat (2) @(posedge core_clk);
            rdchk("status", IDX_STATUS, {~i[4], ~i[3], ~i[2], 1'b0, i[1], i[0], 2'b00});
        end
        wr(IDX_STATUS, 8'hF3);
        rdchk("status after write", IDX_STATUS, 8'h0C);
    endtask

    // Rerouted done pulse, plain external path, sticky status, mask and clear
    task automatic t_irq();
        int n;
        wr(IDX_IRQ_STATUS, 8'h03);
        rdchk("irq status", IDX_IRQ_STATUS, 8'h00);
        wr(IDX_IRQ_MASK, 8'h01);
        rdchk("irq mask", IDX_IRQ_MASK, 8'h01);
        flash_done_irq_enable <= 1'b1;
        ext_irq_one_n         <= 1'b0;
        count(4, n);
        chk("ext ignored", 0, n);
        flash_busy <= 1'b0;
        count(6, n);
        chk("done pulse", 1, n);
        poll_idle();
        chk("irq on", 1, irq);
        rdchk("done event", IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_STATUS, 8'h01);
        count(3, n);
        chk("irq off", 0, irq);
        // Reroute off: a done event must not reach the pin path
        wr(IDX_IRQ_MASK, 8'h00);
        flash_done_irq_enable <= 1'b0;
        ext_irq_one_n         <= 1'b1;
        flash_busy            <= 1'b1;
        count(3, n);
        chk("ext idle", 0, int_one_request);
        flash_busy <= 1'b0;
        count(4, n);
        chk("no done pulse", 0, n);
        ext_irq_one_n <= 1'b0;
        count(3, n);
        chk("ext level", 1, int_one_request);
        rdchk("both events", IDX_IRQ_STATUS, 8'h03);
        chk("irq masked", 0, irq);
        wr(IDX_IRQ_MASK, 8'h02);
        count(3, n);
        chk("irq ext", 1, irq);
        wr(IDX_IRQ_STATUS, 8'h03);
        count(3, n);
        chk("irq cleared", 0, irq);
        rdchk("irq status end", IDX_IRQ_STATUS, 8'h00);
    endtask

    // Main sequence; reset held for two cycles
    initial
    begin
        n_errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'h1;
        {flash_busy, flash_data_load, flash_data_in, double_speed} = '0;
        {lock_one_prog, lock_two_prog, lock_three_prog, flash_done_irq_enable} = '0;
        ext_irq_one_n = 1'b1;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs();
        t_load();
        t_status();
        t_irq();
        finish_test();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #2_000_000;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
